// [rtl/sfepd_core.sv]
// Serial flash command interpreter for array erase, power-down and identifier reads.
//
// Behaviour
// - Array erase opcodes fill memory with FFh.
// - Array erase needs write enable latch set.
// - Erase dropped unless chip select rises after opcode.
// - Chip select rise starts timed array erase.
// - Status reads work during erase; busy shown.
// - Erase completion clears write enable latch.
// - Any block protection refuses the array erase.
// - Power-down entered within delay after opcode.
// - Powered down, only release opcode recognised.
// - Reset always lands in normal operation.
// - Plain release resumes after first delay.
// - Release opcode, three dummies, then ID out.
// - Device identifier repeats until chip select rises.
// - Release with ID resumes after second delay.
// - Release opcode ignored while busy.
// - Address zero gives manufacturer then device code.
// - Address one gives device code first.
// - Manufacturer and device bytes alternate continuously.
// - Standard ID sends manufacturer, type, capacity.
`timescale 1ns/1ps
module sfepd_core
#(
   // Erase length in reference clock cycles; shorten for simulation.
   parameter int unsigned ERASE_CYCLES = (sfepd_pkg::ERASE_TIME_US * 1000000
                                          + sfepd_pkg::CLK_PERIOD_PS - 1)
                                         / sfepd_pkg::CLK_PERIOD_PS,
   // Identity bytes; the values are arbitrary.
   parameter logic [7:0] MFR_CODE = 8'h5a,
   parameter logic [7:0] DEVICE_CODE = 8'h13,
   parameter logic [7:0] MEMORY_TYPE = 8'h30,
   parameter logic [7:0] CAPACITY = 8'h14
)
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Serial pins from the host.
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic serial_data_in_out,
   // Serial data output pin.
   output logic serial_data_out,
   output logic serial_data_out_oe,
   // Write enable control from the write enable and write disable commands.
   input wire logic latch_set,
   input wire logic latch_clear,
   // Block protect bits from the status register.
   input wire logic block_protect_bit2,
   input wire logic block_protect_bit1,
   input wire logic block_protect_bit0,
   // Status.
   output logic busy,
   output logic write_enable_latch,
   output logic power_down,
   // Array fill port toward the memory array.
   output logic array_fill_en,
   output logic [7:0] array_fill_byte,
   output logic erase_done
);
   // Synchronised pins and their previous values.
   logic [2:0] pins;
   logic sclk_s;
   logic cs_n_s;
   logic din_s;
   logic sclk_d;
   logic cs_d;
   // Pin events.
   logic sclk_rise;
   logic sclk_fall;
   logic cs_rise;
   // Input shift register and bit counter.
   logic [31:0] shift_in;
   logic [31:0] next_shift;
   logic [5:0] bitcnt;
   // Command state.
   sfepd_pkg::sfepd_frame_type frame;
   sfepd_pkg::sfepd_frame_type next_frame;
   sfepd_pkg::sfepd_out_type kind;
   sfepd_pkg::sfepd_out_type next_kind;
   sfepd_pkg::sfepd_power_type pw;
   // Armed actions, waiting for chip select to rise.
   logic arm_erase;
   logic arm_pd;
   logic arm_ab;
   logic next_arm_erase;
   logic next_arm_pd;
   logic next_arm_ab;
   logic ab_seen;
   // Timers.
   logic [31:0] erase_cnt;
   logic [31:0] pw_cnt;
   // Output side.
   logic [1:0] idx;
   logic swap;
   logic [2:0] obit;
   logic [6:0] oshift;
   logic buf_in_ready;
   logic buf_out_valid;
   logic [7:0] buf_out_data;
   logic push;
   logic pop;
   logic [2:0] bp;
   logic opcode_edge;

   // Returns the byte to send for a stream kind and position.
   function automatic logic [7:0] id_byte(input sfepd_pkg::sfepd_out_type k,
                                          input logic [1:0] i,
                                          input logic [7:0] st);
      logic [7:0] b;
      b = st;
      case (k)
         sfepd_pkg::ot_status: b = st;
         sfepd_pkg::ot_release_id: b = DEVICE_CODE;
         sfepd_pkg::ot_mfr_dev: b = i[0] ? DEVICE_CODE : MFR_CODE;
         sfepd_pkg::ot_std_id: b = (i == 2'h0) ? MFR_CODE :
                                   (i == 2'h1) ? MEMORY_TYPE : CAPACITY;
         default: b = st;
      endcase
      return b;
   endfunction

   sfepd_sync u_sync
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .pin_async({sclk, cs_n, serial_data_in_out}),
      .pin_sync(pins)
   );

   assign sclk_s = pins[2];
   assign cs_n_s = pins[1];
   assign din_s = pins[0];
   assign bp = {block_protect_bit2, block_protect_bit1, block_protect_bit0};
   assign sclk_rise = sclk_s && !sclk_d && !cs_n_s;
   assign sclk_fall = !sclk_s && sclk_d && !cs_n_s;
   assign cs_rise = cs_n_s && !cs_d;
   assign next_shift = {shift_in[30:0], din_s};
   assign opcode_edge = sclk_rise && frame == sfepd_pkg::fr_opcode
                        && bitcnt == sfepd_pkg::OPCODE_LAST;
   assign power_down = (pw == sfepd_pkg::pw_down);

   // Edge history of the synchronised clock and chip select.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         sclk_d <= 1'b0;
         cs_d <= 1'b1;
      end
      else
      begin
         sclk_d <= sclk_s;
         cs_d <= cs_n_s;
      end
   end

   // Input bits shift in MSB first on rising clock; the count saturates on long frames.
   always_ff @(posedge ref_clk)
   begin
      if (rst || cs_n_s)
      begin
         shift_in <= 32'h0;
         bitcnt <= 6'h0;
      end
      else if (sclk_rise)
      begin
         shift_in <= next_shift;
         if (bitcnt != 6'h3f)
            bitcnt <= bitcnt + 6'h1;
      end
   end

   // Opcode decode: what the frame does next and which action it arms.
   always_comb
   begin
      next_frame = sfepd_pkg::fr_skip;
      next_kind = sfepd_pkg::ot_status;
      next_arm_erase = 1'b0;
      next_arm_pd = 1'b0;
      next_arm_ab = 1'b0;
      if (pw == sfepd_pkg::pw_normal)
      begin
         case (next_shift[7:0])
            sfepd_pkg::OP_ERASE_A, sfepd_pkg::OP_ERASE_B:
               next_arm_erase = !busy && write_enable_latch && bp == 3'h0;
            sfepd_pkg::OP_POWER_DOWN:
               next_arm_pd = !busy;
            sfepd_pkg::OP_READ_STATUS:
               next_frame = sfepd_pkg::fr_out;
            sfepd_pkg::OP_STD_ID:
            begin
               next_frame = busy ? sfepd_pkg::fr_skip : sfepd_pkg::fr_out;
               next_kind = sfepd_pkg::ot_std_id;
            end
            sfepd_pkg::OP_MFR_DEV:
            begin
               next_frame = busy ? sfepd_pkg::fr_skip : sfepd_pkg::fr_header;
               next_kind = sfepd_pkg::ot_mfr_dev;
            end
            sfepd_pkg::OP_RELEASE_ID:
            begin
               next_frame = busy ? sfepd_pkg::fr_skip : sfepd_pkg::fr_header;
               next_kind = sfepd_pkg::ot_release_id;
               next_arm_ab = !busy;
            end
            default:
               next_frame = sfepd_pkg::fr_skip;
         endcase
      end
      else if (pw != sfepd_pkg::pw_waking && next_shift[7:0] == sfepd_pkg::OP_RELEASE_ID)
      begin
         // Powered down: nothing else is recognised, not even status.
         next_frame = sfepd_pkg::fr_header;
         next_kind = sfepd_pkg::ot_release_id;
         next_arm_ab = 1'b1;
      end
   end

   // Frame phase and stream kind; chip select high ends any command.
   always_ff @(posedge ref_clk)
   begin
      if (rst || cs_n_s)
      begin
         frame <= sfepd_pkg::fr_opcode;
         kind <= sfepd_pkg::ot_status;
         swap <= 1'b0;
      end
      else if (sclk_rise)
      begin
         case (frame)
            sfepd_pkg::fr_opcode:
               if (bitcnt == sfepd_pkg::OPCODE_LAST)
               begin
                  frame <= next_frame;
                  kind <= next_kind;
               end
            sfepd_pkg::fr_header:
               if (bitcnt == sfepd_pkg::HEADER_LAST)
               begin
                  frame <= sfepd_pkg::fr_out;
                  swap <= (next_shift[23:0] == sfepd_pkg::ADDR_SWAP);
               end
            default:
               frame <= frame;
         endcase
      end
   end

   // Actions armed by an opcode; any further rising clock edge disarms erase and power-down.
   always_ff @(posedge ref_clk)
   begin
      if (rst || cs_n_s)
      begin
         arm_erase <= 1'b0;
         arm_pd <= 1'b0;
         arm_ab <= 1'b0;
         ab_seen <= 1'b0;
      end
      else if (opcode_edge)
      begin
         arm_erase <= next_arm_erase;
         arm_pd <= next_arm_pd;
         arm_ab <= next_arm_ab;
         ab_seen <= next_arm_ab;
      end
      else if (sclk_rise)
      begin
         arm_erase <= 1'b0;
         arm_pd <= 1'b0;
         arm_ab <= 1'b0;
      end
   end

   // Self-timed array erase; the array is filled with the erased byte while busy.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         busy <= 1'b0;
         erase_cnt <= 32'h0;
         erase_done <= 1'b0;
      end
      else
      begin
         erase_done <= busy && erase_cnt == 32'h0;
         if (cs_rise && arm_erase)
         begin
            busy <= 1'b1;
            erase_cnt <= ERASE_CYCLES - 1;
         end
         else if (busy)
         begin
            if (erase_cnt == 32'h0)
               busy <= 1'b0;
            else
               erase_cnt <= erase_cnt - 32'h1;
         end
      end
   end

   // Fill port toward the array; the fill value is fixed at the erased byte.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         array_fill_en <= 1'b0;
         array_fill_byte <= sfepd_pkg::ERASED_BYTE;
      end
      else
      begin
         array_fill_en <= cs_rise && arm_erase ? 1'b1 : (busy && erase_cnt != 32'h0);
         array_fill_byte <= sfepd_pkg::ERASED_BYTE;
      end
   end

   // Write enable latch; a set arriving with the completion clear wins.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         write_enable_latch <= 1'b0;
      else if (latch_set)
         write_enable_latch <= 1'b1;
      else if (latch_clear || (busy && erase_cnt == 32'h0))
         write_enable_latch <= 1'b0;
   end

   // Power state; reset always returns to normal operation.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         pw <= sfepd_pkg::pw_normal;
         pw_cnt <= 32'h0;
      end
      else
      begin
         case (pw)
            sfepd_pkg::pw_normal:
               if (cs_rise && arm_pd)
               begin
                  pw <= sfepd_pkg::pw_entering;
                  pw_cnt <= sfepd_pkg::TOP_CYC - 1;
               end
            sfepd_pkg::pw_entering, sfepd_pkg::pw_down:
               if (cs_rise && ab_seen)
               begin
                  pw <= sfepd_pkg::pw_waking;
                  pw_cnt <= (arm_ab && bitcnt == sfepd_pkg::OPCODE_BITS) ?
                            sfepd_pkg::RES1_CYC - 1 : sfepd_pkg::RES2_CYC - 1;
               end
               else if (pw == sfepd_pkg::pw_entering)
               begin
                  if (pw_cnt == 32'h0)
                     pw <= sfepd_pkg::pw_down;
                  else
                     pw_cnt <= pw_cnt - 32'h1;
               end
            sfepd_pkg::pw_waking:
               if (pw_cnt == 32'h0)
                  pw <= sfepd_pkg::pw_normal;
               else
                  pw_cnt <= pw_cnt - 32'h1;
            default:
               pw <= sfepd_pkg::pw_normal;
         endcase
      end
   end

   // Byte producer; stalls while the buffer is full, so no byte is skipped.
   assign push = (frame == sfepd_pkg::fr_out) && !cs_n_s;

   always_ff @(posedge ref_clk)
   begin
      if (rst || cs_n_s)
         idx <= 2'h0;
      else if (push && buf_in_ready)
      begin
         if (kind == sfepd_pkg::ot_std_id)
            idx <= (idx == 2'h2) ? 2'h0 : idx + 2'h1;
         else
            idx <= idx + 2'h1;
      end
   end

   sfepd_buf u_buf
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .flush(cs_n_s),
      .in_valid(push),
      .in_ready(buf_in_ready),
      .in_data(id_byte(kind, {idx[1], idx[0] ^ swap},
                       {3'h0, bp, write_enable_latch, busy})),
      .out_valid(buf_out_valid),
      .out_ready(pop),
      .out_data(buf_out_data)
   );

   assign pop = sclk_fall && frame == sfepd_pkg::fr_out && obit == 3'h0;

   // Output shifter: one bit per falling clock, MSB first, a new byte every eighth.
   always_ff @(posedge ref_clk)
   begin
      if (rst || cs_n_s)
      begin
         serial_data_out <= 1'b0;
         serial_data_out_oe <= 1'b0;
         obit <= 3'h0;
         oshift <= 7'h0;
      end
      else
      begin
         serial_data_out_oe <= (frame == sfepd_pkg::fr_out);
         if (pop)
         begin
            // An empty buffer cannot happen at this clock rate; ones are sent if it does.
            serial_data_out <= buf_out_valid ? buf_out_data[7] : 1'b1;
            oshift <= buf_out_valid ? buf_out_data[6:0] : 7'h7f;
            obit <= 3'h7;
         end
         else if (sclk_fall && frame == sfepd_pkg::fr_out)
         begin
            serial_data_out <= oshift[6];
            oshift <= {oshift[5:0], 1'b1};
            obit <= obit - 3'h1;
         end
      end
   end

   // Checks.
   localparam int TOP_MAX = sfepd_pkg::TOP_CYC;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_erase_needs_latch: assert property ($rose(busy) |-> $past(write_enable_latch))
      else $error("erase started without write enable");
   a_erase_protect: assert property ($rose(busy) |-> $past(bp) == 3'h0)
      else $error("erase started on protected array");
   a_erase_abort: assert property (arm_erase && sclk_rise |=> !arm_erase)
      else $error("erase still armed after extra clock");
   a_erase_start: assert property (cs_rise && arm_erase |=> busy && array_fill_en)
      else $error("erase did not start at chip select rise");
   a_fill_value: assert property (array_fill_en |-> array_fill_byte == sfepd_pkg::ERASED_BYTE)
      else $error("fill byte is not erased value");
   a_latch_cleared: assert property ($fell(busy) && !$past(latch_set)
                                     |-> !write_enable_latch)
      else $error("write enable kept after erase");
   a_pd_entry: assert property (cs_rise && arm_pd && pw == sfepd_pkg::pw_normal
                                |=> ##[1:TOP_MAX] power_down)
      else $error("power-down not entered in time");
   a_pd_filter: assert property (pw == sfepd_pkg::pw_down && frame != sfepd_pkg::fr_opcode
                                 && frame != sfepd_pkg::fr_skip
                                 |-> kind == sfepd_pkg::ot_release_id)
      else $error("command other than release accepted in power-down");
   a_reset_normal: assert property ($past(rst) |-> !power_down)
      else $error("power-down after reset");
   a_ab_busy: assert property (opcode_edge && busy |=> !ab_seen)
      else $error("release opcode acted on while busy");

   c_erase: cover property ($rose(busy));
   c_power_down: cover property ($rose(power_down));
   c_wake: cover property ($fell(power_down));
   c_swapped_ids: cover property ($rose(swap));
endmodule

// [rtl/sfepd_pkg.sv]
// Shared constants and types for the serial flash erase, power-down and ID command block.
package sfepd_pkg;
   // Reference clock period in picoseconds.
   localparam int unsigned CLK_PERIOD_PS = 4000;
   // Whole-array erase duration, in microseconds.
   localparam int unsigned ERASE_TIME_US = 1000;
   // Power-down entry delay, in nanoseconds; a longest time, so it rounds down.
   localparam int unsigned POWER_DOWN_DELAY_NS = 3000;
   // Plain release delay and release delay after an identifier read, in nanoseconds.
   localparam int unsigned RELEASE_DELAY_PLAIN_NS = 3000;
   localparam int unsigned RELEASE_DELAY_WITH_ID_NS = 1800;
   // Cycle counts derived from the times above.
   localparam int unsigned TOP_RAW = POWER_DOWN_DELAY_NS * 1000 / CLK_PERIOD_PS;
   localparam int unsigned TOP_CYC = (TOP_RAW < 1) ? 1 : TOP_RAW;
   localparam int unsigned RES1_CYC = (RELEASE_DELAY_PLAIN_NS * 1000 + CLK_PERIOD_PS - 1)
                                      / CLK_PERIOD_PS;
   localparam int unsigned RES2_CYC = (RELEASE_DELAY_WITH_ID_NS * 1000 + CLK_PERIOD_PS - 1)
                                      / CLK_PERIOD_PS;
   // Opcodes.
   localparam logic [7:0] OP_ERASE_A = 8'hc7;
   localparam logic [7:0] OP_ERASE_B = 8'h60;
   localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
   localparam logic [7:0] OP_RELEASE_ID = 8'hab;
   localparam logic [7:0] OP_MFR_DEV = 8'h90;
   localparam logic [7:0] OP_STD_ID = 8'h9f;
   localparam logic [7:0] OP_READ_STATUS = 8'h05;
   // Erased byte value and the address that swaps the identifier order.
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [23:0] ADDR_SWAP = 24'h000001;
   // Last bit indexes of the opcode and of opcode plus three header bytes, and the opcode bit count.
   localparam logic [5:0] OPCODE_LAST = 6'h07;
   localparam logic [5:0] HEADER_LAST = 6'h1f;
   localparam logic [5:0] OPCODE_BITS = 6'h08;
   // Status byte field positions.
   localparam int unsigned ST_BUSY = 0;
   localparam int unsigned ST_LATCH = 1;
   localparam int unsigned ST_BP_LSB = 2;
   // Synchroniser reset value, ordered {sclk, cs_n, data}; chip select idles high.
   localparam logic [2:0] SYNC_RESET = 3'h2;
   // Frame phase of the serial command.
   typedef enum logic [1:0] {fr_opcode, fr_header, fr_out, fr_skip} sfepd_frame_type;
   // Power state of the device.
   typedef enum logic [1:0] {pw_normal, pw_entering, pw_down, pw_waking} sfepd_power_type;
   // Kind of byte stream sent back.
   typedef enum logic [1:0] {ot_status, ot_release_id, ot_mfr_dev, ot_std_id} sfepd_out_type;
endpackage

// [rtl/sfepd_sync.sv]
// Two-flop synchroniser for the serial pins.
`timescale 1ns/1ps
module sfepd_sync
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Asynchronous pins and their synchronised copies.
   input wire logic [2:0] pin_async,
   output logic [2:0] pin_sync
);
   // First stage; read by the second stage only.
   logic [2:0] meta;

   // Both stages reset to the idle pin levels so no false edge is seen after reset.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         meta <= sfepd_pkg::SYNC_RESET;
         pin_sync <= sfepd_pkg::SYNC_RESET;
      end
      else
      begin
         meta <= pin_async;
         pin_sync <= meta;
      end
   end
endmodule

// [rtl/sfepd_buf.sv]
// Two-entry byte buffer with valid and ready on both sides.
`timescale 1ns/1ps
module sfepd_buf
(
   // Clock, reset and flush.
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic flush,
   // Filling side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [7:0] in_data,
   // Draining side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [7:0] out_data
);
   // Storage, entry zero is the head.
   logic [7:0] slot [0:1];
   // Number of bytes held, zero to two.
   logic [1:0] count;
   logic push;
   logic pop;

   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = slot[0];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Occupancy; a flush wins because the frame that owned the bytes is gone.
   always_ff @(posedge ref_clk)
   begin
      if (rst || flush)
         count <= 2'h0;
      else if (push && !pop)
         count <= count + 2'h1;
      else if (pop && !push)
         count <= count - 2'h1;
   end

   // Data moves toward the head on a pop; a push lands behind whatever remains.
   always_ff @(posedge ref_clk)
   begin
      if (pop)
      begin
         slot[0] <= (push && count == 2'h1) ? in_data : slot[1];
         if (push && count == 2'h2)
            slot[1] <= in_data;
      end
      else if (push)
      begin
         if (count == 2'h0)
            slot[0] <= in_data;
         else
            slot[1] <= in_data;
      end
   end
endmodule

// [testbench/sfepd_host.sv]
// SPI host model that frames commands and collects the reply bits.
`timescale 1ns/1ps
module sfepd_host
(
   // Reference clock that paces the link.
   input wire logic ref_clk,
   // Serial pins toward the device.
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso
);
   // The link idles with its clock low and the device deselected.
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // Half of a 160 ns link period.
   task automatic half();
      repeat (20) @(posedge ref_clk);
   endtask
   // Sends ntx bits of tx, then clocks nrx more bits in from the device.
   task automatic xfer(input logic [31:0] tx, input int ntx, input int nrx,
                       output logic [31:0] rx);
      rx = 32'h0;
      @(posedge ref_clk);
      cs_n <= 1'b0;
      for (int i = 0; i < ntx + nrx; i++)
      begin
         if (i < ntx)
            mosi <= tx[ntx - 1 - i];
         half();
         sclk <= 1'b1;
         // Reply bits are taken at the rise, long after they settled.
         if (i >= ntx)
            rx = {rx[30:0], miso};
         half();
         sclk <= 1'b0;
      end
      half();
      // Deselect before any further rise, or writes would be dropped.
      cs_n <= 1'b1;
      // A released line must not keep showing its last bit.
      mosi <= ~mosi;
      half();
   endtask
endmodule

// [testbench/sfepd_core_tb.sv]
// Self-checking bench for the erase, power-down and identifier block.
`timescale 1ns/1ps
module sfepd_core_tb;
   // Short erase so a run stays brief; identity values are arbitrary.
   localparam int unsigned ERASE = 2000;
   localparam logic [7:0] MFR = 8'hc3;
   localparam logic [7:0] DEV = 8'h2e;
   localparam logic [7:0] TYP = 8'h41;
   localparam logic [7:0] CAP = 8'h17;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic latch_set = 1'b0;
   logic latch_clear = 1'b0;
   logic [2:0] bp = 3'h0;
   logic sclk, cs_n, mosi, miso, oe, busy, latch, pd, fill_en, done;
   logic [7:0] fill_byte;
   logic [31:0] rx;
   int miscompares = 0;
   int comparisons = 0;
   // Cycles in which the device drove its data pin; a read must raise it, a refused one not.
   int oe_seen = 0;
   // A 4 ns clock.
   always #2 ref_clk = ~ref_clk;
   // Counts driven cycles so the enable can be judged after a whole frame.
   always @(posedge ref_clk)
   begin
      if (oe === 1'b1)
         oe_seen <= oe_seen + 1;
   end
   sfepd_host u_host (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
   sfepd_core #(.ERASE_CYCLES(ERASE), .MFR_CODE(MFR), .DEVICE_CODE(DEV), .MEMORY_TYPE(TYP),
      .CAPACITY(CAP)) u_dut (.ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
      .serial_data_in_out(mosi), .serial_data_out(miso), .serial_data_out_oe(oe),
      .latch_set(latch_set), .latch_clear(latch_clear), .block_protect_bit2(bp[2]),
      .block_protect_bit1(bp[1]), .block_protect_bit0(bp[0]), .busy(busy),
      .write_enable_latch(latch), .power_down(pd), .array_fill_en(fill_en),
      .array_fill_byte(fill_byte), .erase_done(done));
   // Counts one comparison and reports a mismatch.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // One-cycle pulse on the set or the clear of the latch.
   task automatic arm(input logic clr);
      latch_set <= ~clr;
      latch_clear <= clr;
      cyc(1);
      latch_set <= 1'b0;
      latch_clear <= 1'b0;
      cyc(1);
   endtask
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic t_reset();
      chk("reset outputs", {4'h0, 8'hff}, {busy, latch, pd, oe, fill_byte});
      $display("t_reset done");
   endtask
   // Every identifier format; all but the standard ID are read past one full pass to see the repetition.
   task automatic t_ids();
      int n;
      n = oe_seen;
      u_host.xfer(32'h9f, 8, 24, rx);
      chk("standard id", {8'h0, MFR, TYP, CAP}, rx);
      chk("oe during read", 1'b1, oe_seen > n);
      u_host.xfer(32'h90000000, 32, 32, rx);
      chk("mfr dev", {MFR, DEV, MFR, DEV}, rx);
      u_host.xfer(32'h90000001, 32, 32, rx);
      chk("dev mfr", {DEV, MFR, DEV, MFR}, rx);
      u_host.xfer(32'hab000000, 32, 24, rx);
      chk("device id", {8'h0, DEV, DEV, DEV}, rx);
      $display("t_ids done");
   endtask
   // Erases refused for a clear latch, for protection and for a late deselect.
   task automatic t_refuse();
      arm(1'b0);
      arm(1'b1);
      u_host.xfer(32'hc7, 8, 0, rx);
      chk("no latch", 1'b0, busy);
      arm(1'b0);
      bp <= 3'h2;
      u_host.xfer(32'hc7, 8, 0, rx);
      chk("protected", 1'b0, busy);
      bp <= 3'h0;
      u_host.xfer(32'h18e, 9, 0, rx);
      chk("late deselect", 1'b0, busy);
      arm(1'b1);
      $display("t_refuse done");
   endtask
   task automatic t_erase(input logic [7:0] op);
      int n;
      arm(1'b0);
      u_host.xfer({24'h0, op}, 8, 0, rx);
      chk("erase start", {2'b11, 8'hff}, {fill_en, busy, fill_byte});
      u_host.xfer(32'h05, 8, 8, rx);
      chk("status busy", 32'h03, rx);
      u_host.xfer(32'hab, 8, 0, rx);
      chk("release while busy", 2'b10, {busy, pd});
      for (n = 0; n < 4000 && done !== 1'b1; n++)
         cyc(1);
      chk("erase end", 3'b100, {done, busy, latch});
      u_host.xfer(32'h05, 8, 8, rx);
      chk("status idle", 32'h00, rx);
      $display("t_erase done");
   endtask
   task automatic t_power();
      int n;
      u_host.xfer(32'hb9, 8, 0, rx);
      cyc(sfepd_pkg::TOP_CYC);
      chk("powered down", 1'b1, pd);
      n = oe_seen;
      u_host.xfer(32'h9f, 8, 24, rx);
      chk("ignored id", 32'h0, rx);
      chk("oe in power-down", n, oe_seen);
      u_host.xfer(32'hab, 8, 0, rx);
      chk("released", 1'b0, pd);
      cyc(sfepd_pkg::RES1_CYC);
      u_host.xfer(32'h9f, 8, 24, rx);
      chk("id after release", {8'h0, MFR, TYP, CAP}, rx);
      u_host.xfer(32'hb9, 8, 0, rx);
      cyc(sfepd_pkg::TOP_CYC);
      u_host.xfer(32'hab000000, 32, 16, rx);
      chk("id on wake", {16'h0, DEV, DEV}, rx);
      cyc(sfepd_pkg::RES2_CYC);
      u_host.xfer(32'h9f, 8, 24, rx);
      chk("id after wake", {8'h0, MFR, TYP, CAP}, rx);
      $display("t_power done");
   endtask
   // Cuts a hang short; the tests need about two sevenths of this.
   initial
   begin
      cyc(90000);
      chk("watchdog", 32'h0, 32'h1);
      wrap_up();
   end
   initial
   begin
      cyc(8);
      rst <= 1'b0;
      cyc(4);
      t_reset();
      t_ids();
      t_refuse();
      t_erase(8'hc7);
      t_erase(8'h60);
      t_power();
      wrap_up();
   end
endmodule
